/* hw/afesc_regs.vh */
`ifndef AFESC_REGS_VH
`define AFESC_REGS_VH
`define AFESC_REG_MODE 3'h0
`define AFESC_REG_CLK 3'h1
`define AFESC_REG_PWR 3'h2
`define AFESC_REG_GAIN 3'h3
`define AFESC_REG_CONV 3'h4
`define AFESC_REG_ANA 3'h5
`define AFESC_REG_RESET 8'h00
`define AFESC_MODE_OPMODE 0
`define AFESC_MODE_MIXED 1
`define AFESC_MODE_DLB 2
`define AFESC_MODE_PLB 3
`define AFESC_MODE_SWRST 7
`define AFESC_CLK_ECHO 7
`define AFESC_PWR_GLOBAL 0
`define AFESC_PWR_ADC 3
`define AFESC_PWR_DAC 4
`define AFESC_PWR_REF 5
`define AFESC_PWR_REFOUT 6
`define AFESC_W_CTRL 15
`define AFESC_W_READ 14
`define AFESC_RST_CYCLES 3'h4
`define AFESC_FIRST_FS 12'h7FF
`define AFESC_WORD_BITS 5'h10
`endif

/* hw/afesc_fifo.v */
`timescale 1ns/10ps
module afesc_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire ref_clk,
    input wire rst_n,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output reg [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wr_ff;
    reg [AW:0] rd_ff;
    reg vld_ff;
    wire [AW:0] used = wr_ff - rd_ff;
    wire empty = (used == {(AW+1){1'b0}});
    wire pop = !empty && (!vld_ff || out_ready);
    // Output register counts as a place so the buffer never holds more than DEPTH
    wire [AW:0] occ = used + {{AW{1'b0}}, vld_ff};
    assign in_ready = (occ < DEPTH);
    assign out_valid = vld_ff;
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            wr_ff <= {(AW+1){1'b0}};
            rd_ff <= {(AW+1){1'b0}};
            vld_ff <= 1'b0;
            out_data <= {WIDTH{1'b0}};
        end else begin
            if (in_valid && in_ready) begin
                mem[wr_ff[AW-1:0]] <= in_data;
                wr_ff <= wr_ff + 1'b1;
            end
            if (pop) begin
                out_data <= mem[rd_ff[AW-1:0]];
                rd_ff <= rd_ff + 1'b1;
                vld_ff <= 1'b1;
            end else if (out_ready) begin
                vld_ff <= 1'b0;
            end
        end
    end
endmodule

/* hw/afesc_top.v */
// Functional notes
// [RULE1] Hardware reset clears all registers to zero
// [RULE2] Mode bit 7 write triggers register reset
// [RULE3] Reset takes four master clock cycles
// [RULE4] After reset device is in program mode
// [RULE5] Zero registers give sclk/8, sample/2048
// [RULE6] First output frame sync 2048 cycles after
// [RULE7] Host ignores output words in program mode
// [RULE8] Section powered by own or global bit
// [RULE9] Global clear keeps individually enabled sections
// [RULE10] Power bit 6 enables reference output
// [RULE11] Six 8-bit registers, addresses 6-7 reserved
// [RULE12] Bit 15 marks control versus data word
// [RULE13] Write when read bit low, address zero
// [RULE14] Read places register data into output
// [RULE15] Nonzero device address decremented and passed
// [RULE16] Register number 10:8, data 7:0
// [RULE17] Mode register field layout
// [RULE18] Clock register field layout
// [RULE19] Host writes zero to reserved power bits
// [RULE20] Registers update on serial clock falling edge
// [RULE21] Plain data mode ignores control words
// [RULE22] Reserved addresses read zero, writes ignored
`timescale 1ns/10ps
`include "afesc_regs.vh"
module afesc_top #(
    parameter WORD_W = 16
) (
    input wire ref_clk,
    input wire rst_n,
    input wire serial_in,
    input wire input_frame_sync,
    output reg serial_out_ff,
    output reg output_frame_sync_ff,
    output reg serial_clk_ff,
    output reg adc_power_ff,
    output reg dac_power_ff,
    output reg ref_power_ff,
    output reg ref_output_enable_ff,
    output reg operating_mode_select_ff,
    output reg mixed_mode_enable_ff,
    output reg digital_loopback_enable_ff,
    output reg port_loopback_enable_ff,
    output reg [2:0] cascade_count_ff,
    output reg control_echo_enable_ff,
    output reg [1:0] sample_rate_ff,
    output reg [1:0] serial_clock_divider_ff,
    output reg [2:0] master_divider_ff,
    output reg [7:0] gain_ff,
    output reg [7:0] conv_timing_ff,
    output reg [7:0] analog_path_ff,
    output reg dac_word_valid_ff,
    output reg [WORD_W-1:0] dac_word_ff
);
    reg [7:0] mode_ff;
    reg [7:0] clk_ff;
    reg [7:0] pwr_ff;
    reg [7:0] gain_r_ff;
    reg [7:0] conv_ff;
    reg [7:0] ana_ff;
    reg [2:0] rst_cnt_ff;
    reg [2:0] sdiv_ff;
    reg [10:0] samp_ff;
    reg [11:0] first_ff;
    reg first_done_ff;
    reg [WORD_W-1:0] rx_ff;
    reg [4:0] rx_cnt_ff;
    reg rx_busy_ff;
    reg [WORD_W-1:0] tx_ff;
    reg [4:0] tx_cnt_ff;
    reg [2:0] fs_cnt_ff;
    reg sclk_fall_ff;
    wire [7:0] rd_data;
    wire rst_active = (rst_cnt_ff != 3'h0);
    wire [WORD_W-1:0] word_done = {rx_ff[WORD_W-2:0], serial_in};
    wire rx_last = rx_busy_ff && sclk_fall_ff && (rx_cnt_ff == `AFESC_WORD_BITS - 5'h1);
    // [RULE12] control flag
    wire is_ctrl = word_done[`AFESC_W_CTRL];
    wire [2:0] dev_addr = word_done[13:11];
    wire [2:0] reg_addr = word_done[10:8];
    wire [7:0] reg_data = word_done[7:0];
    wire opmode = mode_ff[`AFESC_MODE_OPMODE];
    wire mixed = mode_ff[`AFESC_MODE_MIXED];
    // [RULE21] control gate
    wire ctrl_ok = !opmode || mixed;
    wire ctrl_word = rx_last && is_ctrl && ctrl_ok && !rst_active;
    wire do_write = ctrl_word && !word_done[`AFESC_W_READ] && dev_addr == 3'h0;
    wire do_read = ctrl_word && word_done[`AFESC_W_READ] && dev_addr == 3'h0;
    wire pass_on = ctrl_word && dev_addr != 3'h0;
    wire data_word = rx_last && opmode && (!mixed || !is_ctrl) && !rst_active;
    wire [3:0] sdiv_top;
    wire [10:0] samp_top;
    wire sample_event;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [WORD_W-1:0] fifo_out_data;
    // [RULE5] dividers from zero defaults
    assign sdiv_top = (clk_ff[3:2] == 2'h0) ? 4'h3 : (clk_ff[3:2] == 2'h1) ? 4'h1 : 4'h0;
    assign samp_top = (clk_ff[1:0] == 2'h0) ? 11'h7FF : (clk_ff[1:0] == 2'h1) ? 11'h3FF :
        (clk_ff[1:0] == 2'h2) ? 11'h1FF : 11'h0FF;
    // [RULE6] first frame sync delay
    assign sample_event = first_done_ff ? (samp_ff == samp_top) : (first_ff == `AFESC_FIRST_FS);
    // [RULE11] reserved reads zero
    // [RULE22] reserved addresses
    assign rd_data = (reg_addr == `AFESC_REG_MODE) ? mode_ff :
        (reg_addr == `AFESC_REG_CLK) ? clk_ff :
        (reg_addr == `AFESC_REG_PWR) ? pwr_ff :
        (reg_addr == `AFESC_REG_GAIN) ? gain_r_ff :
        (reg_addr == `AFESC_REG_CONV) ? conv_ff :
        (reg_addr == `AFESC_REG_ANA) ? ana_ff : `AFESC_REG_RESET;
    afesc_fifo #(.WIDTH(WORD_W), .DEPTH(8), .AW(3)) u_fifo (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .in_valid(data_word),
        .in_ready(fifo_in_ready),
        .in_data(mixed ? {word_done[WORD_W-2:0], 1'b0} : word_done),
        .out_valid(fifo_out_valid),
        .out_ready(sample_event),
        .out_data(fifo_out_data)
    );
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            sdiv_ff <= 3'h0;
            serial_clk_ff <= 1'b0;
            sclk_fall_ff <= 1'b0;
            samp_ff <= 11'h000;
            first_ff <= 12'h000;
            first_done_ff <= 1'b0;
        end else begin
            sclk_fall_ff <= 1'b0;
            if (sdiv_ff[2:0] >= sdiv_top[2:0]) begin
                sdiv_ff <= 3'h0;
                serial_clk_ff <= !serial_clk_ff;
                sclk_fall_ff <= serial_clk_ff;
            end else begin
                sdiv_ff <= sdiv_ff + 3'h1;
            end
            if (!first_done_ff) begin
                first_ff <= first_ff + 12'h001;
                if (first_ff == `AFESC_FIRST_FS) begin
                    first_done_ff <= 1'b1;
                end
            end else if (samp_ff >= samp_top) begin
                samp_ff <= 11'h000;
            end else begin
                samp_ff <= samp_ff + 11'h001;
            end
        end
    end
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            rx_ff <= {WORD_W{1'b0}};
            rx_cnt_ff <= 5'h00;
            rx_busy_ff <= 1'b0;
        end else if (sclk_fall_ff) begin
            if (input_frame_sync && !rx_busy_ff) begin
                rx_busy_ff <= 1'b1;
                rx_cnt_ff <= 5'h01;
                rx_ff <= {{(WORD_W-1){1'b0}}, serial_in};
            end else if (rx_busy_ff) begin
                rx_ff <= word_done;
                rx_cnt_ff <= rx_cnt_ff + 5'h01;
                if (rx_last) begin
                    rx_busy_ff <= 1'b0;
                end
            end
        end
    end
    // [RULE20] register writes on falling edge
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            // [RULE1] hardware clear
            mode_ff <= `AFESC_REG_RESET;
            clk_ff <= `AFESC_REG_RESET;
            pwr_ff <= `AFESC_REG_RESET;
            gain_r_ff <= `AFESC_REG_RESET;
            conv_ff <= `AFESC_REG_RESET;
            ana_ff <= `AFESC_REG_RESET;
            rst_cnt_ff <= `AFESC_RST_CYCLES;
        end else if (rst_active) begin
            // [RULE3] four cycle reset
            // [RULE4] program mode default
            mode_ff <= `AFESC_REG_RESET;
            clk_ff <= `AFESC_REG_RESET;
            pwr_ff <= `AFESC_REG_RESET;
            gain_r_ff <= `AFESC_REG_RESET;
            conv_ff <= `AFESC_REG_RESET;
            ana_ff <= `AFESC_REG_RESET;
            rst_cnt_ff <= rst_cnt_ff - 3'h1;
        end else if (do_write) begin
            // [RULE13] addressed write
            // [RULE16] field extraction
            case (reg_addr)
                `AFESC_REG_MODE: begin
                    // [RULE2] software reset
                    if (reg_data[`AFESC_MODE_SWRST]) begin
                        rst_cnt_ff <= `AFESC_RST_CYCLES;
                    end else begin
                        mode_ff <= reg_data;
                    end
                end
                `AFESC_REG_CLK: clk_ff <= reg_data;
                `AFESC_REG_PWR: pwr_ff <= reg_data;
                `AFESC_REG_GAIN: gain_r_ff <= reg_data;
                `AFESC_REG_CONV: conv_ff <= reg_data;
                `AFESC_REG_ANA: ana_ff <= reg_data;
                default: rst_cnt_ff <= 3'h0;
            endcase
        end
    end
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            tx_ff <= {WORD_W{1'b0}};
            tx_cnt_ff <= 5'h00;
            serial_out_ff <= 1'b0;
            output_frame_sync_ff <= 1'b0;
            fs_cnt_ff <= 3'h0;
            dac_word_valid_ff <= 1'b0;
            dac_word_ff <= {WORD_W{1'b0}};
        end else begin
            output_frame_sync_ff <= 1'b0;
            dac_word_valid_ff <= 1'b0;
            if (sample_event) begin
                output_frame_sync_ff <= 1'b1;
                tx_ff <= mixed ? {1'b0, fifo_out_data[WORD_W-1:1]} : fifo_out_data;
                tx_cnt_ff <= `AFESC_WORD_BITS;
                dac_word_valid_ff <= fifo_out_valid;
                dac_word_ff <= fifo_out_data;
            end else if (do_read) begin
                // [RULE14] read back
                tx_ff <= {word_done[WORD_W-1:8], rd_data};
                tx_cnt_ff <= `AFESC_WORD_BITS;
            end else if (pass_on) begin
                // [RULE15] decrement and pass
                tx_ff <= {word_done[15:14], dev_addr - 3'h1, word_done[10:0]};
                tx_cnt_ff <= `AFESC_WORD_BITS;
            end else if (ctrl_word && clk_ff[`AFESC_CLK_ECHO]) begin
                tx_ff <= word_done;
                tx_cnt_ff <= `AFESC_WORD_BITS;
            end else if (sclk_fall_ff && tx_cnt_ff != 5'h00) begin
                serial_out_ff <= tx_ff[WORD_W-1];
                tx_ff <= {tx_ff[WORD_W-2:0], 1'b0};
                tx_cnt_ff <= tx_cnt_ff - 5'h01;
            end
            if (data_word) begin
                fs_cnt_ff <= (fs_cnt_ff >= mode_ff[6:4]) ? 3'h0 : fs_cnt_ff + 3'h1;
            end
        end
    end
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            adc_power_ff <= 1'b0;
            dac_power_ff <= 1'b0;
            ref_power_ff <= 1'b0;
            ref_output_enable_ff <= 1'b0;
            operating_mode_select_ff <= 1'b0;
            mixed_mode_enable_ff <= 1'b0;
            digital_loopback_enable_ff <= 1'b0;
            port_loopback_enable_ff <= 1'b0;
            cascade_count_ff <= 3'h0;
            control_echo_enable_ff <= 1'b0;
            sample_rate_ff <= 2'h0;
            serial_clock_divider_ff <= 2'h0;
            master_divider_ff <= 3'h0;
            gain_ff <= `AFESC_REG_RESET;
            conv_timing_ff <= `AFESC_REG_RESET;
            analog_path_ff <= `AFESC_REG_RESET;
        end else begin
            // [RULE8] own or global enable
            // [RULE9] individual bit holds power
            adc_power_ff <= pwr_ff[`AFESC_PWR_ADC] | pwr_ff[`AFESC_PWR_GLOBAL];
            dac_power_ff <= pwr_ff[`AFESC_PWR_DAC] | pwr_ff[`AFESC_PWR_GLOBAL];
            ref_power_ff <= pwr_ff[`AFESC_PWR_REF] | pwr_ff[`AFESC_PWR_GLOBAL];
            // [RULE10] reference output
            ref_output_enable_ff <= pwr_ff[`AFESC_PWR_REFOUT];
            // [RULE17] mode fields
            operating_mode_select_ff <= opmode;
            mixed_mode_enable_ff <= mixed;
            digital_loopback_enable_ff <= mode_ff[`AFESC_MODE_DLB];
            port_loopback_enable_ff <= mode_ff[`AFESC_MODE_PLB];
            cascade_count_ff <= mode_ff[6:4];
            // [RULE18] clock fields
            control_echo_enable_ff <= clk_ff[`AFESC_CLK_ECHO];
            sample_rate_ff <= clk_ff[1:0];
            serial_clock_divider_ff <= clk_ff[3:2];
            master_divider_ff <= clk_ff[6:4];
            gain_ff <= gain_r_ff;
            conv_timing_ff <= conv_ff;
            analog_path_ff <= ana_ff;
        end
    end
endmodule

/* tb/afesc_props.sv */
`timescale 1ns/10ps
module afesc_props (
    input wire ref_clk,
    input wire rst_n,
    input wire serial_out_ff,
    input wire output_frame_sync_ff,
    input wire serial_clk_ff,
    input wire adc_power_ff,
    input wire dac_power_ff,
    input wire ref_power_ff,
    input wire operating_mode_select_ff,
    input wire mixed_mode_enable_ff,
    input wire [2:0] cascade_count_ff,
    input wire [7:0] gain_ff,
    input wire dac_word_valid_ff
);
    wire [16:0] cfg = {operating_mode_select_ff, mixed_mode_enable_ff, cascade_count_ff,
        gain_ff, adc_power_ff, dac_power_ff, ref_power_ff, 1'b0};
    reg [11:0] gap_ff;
    wire [11:0] nxt_gap = output_frame_sync_ff ? 12'h000 :
        (gap_ff == 12'hFFF) ? gap_ff : gap_ff + 12'h001;
    // Saturates so a stalled frame sync cannot wrap into the legal window
    always @(posedge ref_clk) begin
        gap_ff <= !rst_n ? 12'h000 : nxt_gap;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence sclk_cycle;
        serial_clk_ff [*4] ##1 !serial_clk_ff [*4] ##1 serial_clk_ff;
    endsequence
    sequence cfg_idle;
        (cfg == 17'h0) [*4];
    endsequence
    chk_reset_clear: assert property (disable iff (1'b0) !rst_n |=>
        cfg == 17'h0 && !serial_clk_ff && !output_frame_sync_ff && !dac_word_valid_ff)
        else $error("outputs not cleared by reset");
    chk_reset_hold: assert property ($rose(rst_n) |-> cfg_idle)
        else $error("configuration changed during reset settling");
    chk_sclk_rate: assert property ($rose(serial_clk_ff) |-> sclk_cycle)
        else $error("serial clock is not master clock over 8");
    chk_fs_gap: assert property (output_frame_sync_ff |->
        gap_ff >= 12'h7FF && gap_ff <= 12'h801)
        else $error("frame sync spacing is not 2048 cycles");
    chk_fs_single: assert property (output_frame_sync_ff |=> !output_frame_sync_ff)
        else $error("frame sync longer than one cycle");
    chk_data_lock: assert property (
        operating_mode_select_ff && !mixed_mode_enable_ff |=> $stable(cfg))
        else $error("configuration changed in data mode");
    chk_sout_hold: assert property ($rose(serial_clk_ff) |-> $stable(serial_out_ff))
        else $error("serial output moved on rising serial clock");
    chk_dac_mode: assert property (dac_word_valid_ff |-> operating_mode_select_ff)
        else $error("data word taken in program mode");
endmodule
bind afesc_top afesc_props u_props (.*);

/* tb/afesc_host.sv */
`timescale 1ns/10ps
module afesc_host (
    input wire ref_clk,
    input wire serial_clk,
    input wire serial_out,
    output logic serial_in,
    output logic frame_sync
);
    logic last_clk;
    initial begin
        serial_in = 1'b0;
        frame_sync = 1'b0;
        last_clk = 1'b0;
    end
    always @(posedge ref_clk) last_clk <= serial_clk;
    task wait_rise;
        begin
            @(posedge ref_clk);
            while (!(serial_clk && !last_clk)) @(posedge ref_clk);
        end
    endtask
    // Launch on rising serial clock so the device samples mid-bit
    task xfer(input logic [15:0] w, input logic cap, output logic [15:0] rx);
        integer i;
        begin
            rx = 16'h0000;
            for (i = 15; i >= 0; i--) begin
                wait_rise;
                serial_in <= w[i];
                frame_sync <= (i == 15);
            end
            wait_rise;
            frame_sync <= 1'b0;
            serial_in <= ~w[0];
            for (i = 15; i >= 0 && cap; i--) begin
                wait_rise;
                rx[i] = serial_out;
            end
        end
    endtask
endmodule

/* tb/afesc_tb.sv */
`timescale 1ns/10ps
module tb;
    logic ref_clk, rst_n, sdi, fsi, sdo, fso, sclk, adc_p, dac_p, ref_p, refout, opm, mix;
    logic digital_loopback_enable, plb, echo, dvalid;
    logic [2:0] casc, mdiv;
    logic [1:0] srate, sdiv;
    logic [7:0] gain, conv, ana;
    logic [15:0] dword, rx;
    logic [7:0] regv [0:7];
    logic [7:0] pwv [0:3] = '{8'h01, 8'h20, 8'h48, 8'h10};
    logic [3:0] pwe [0:3] = '{4'hE, 4'h2, 4'h9, 4'h4};
    logic [15:0] got_q [$];
    integer failures = 0;
    integer cmp_count = 0;
    integer i;
    afesc_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .serial_in(sdi), .input_frame_sync(fsi),
        .serial_out_ff(sdo), .output_frame_sync_ff(fso), .serial_clk_ff(sclk),
        .adc_power_ff(adc_p), .dac_power_ff(dac_p), .ref_power_ff(ref_p),
        .ref_output_enable_ff(refout), .operating_mode_select_ff(opm),
        .mixed_mode_enable_ff(mix), .digital_loopback_enable_ff(digital_loopback_enable),
        .port_loopback_enable_ff(plb), .cascade_count_ff(casc), .control_echo_enable_ff(echo),
        .sample_rate_ff(srate), .serial_clock_divider_ff(sdiv), .master_divider_ff(mdiv),
        .gain_ff(gain), .conv_timing_ff(conv), .analog_path_ff(ana),
        .dac_word_valid_ff(dvalid), .dac_word_ff(dword));
    afesc_host host (.ref_clk(ref_clk), .serial_clk(sclk), .serial_out(sdo),
        .serial_in(sdi), .frame_sync(fsi));
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        if (dvalid === 1'b1) got_q.push_back(dword);
    end
    function logic [47:0] cfg();
        cfg = {5'h00, opm, mix, digital_loopback_enable, plb, casc, echo, srate, sdiv, mdiv, gain, conv, ana,
            adc_p, dac_p, ref_p, refout};
    endfunction
    task check(input logic [47:0] got, input logic [47:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("ERROR at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wait_fs;
        integer n;
        begin
            n = 0;
            while (fso !== 1'b1 && n < 3000) begin
                @(posedge ref_clk);
                n = n + 1;
            end
            check(n < 3000, 1'b1);
            @(posedge ref_clk);
        end
    endtask
    // Words go out just after a sample event so none is overwritten
    task txn(input logic [15:0] w, input logic cap);
        begin
            wait_fs;
            host.xfer(w, cap, rx);
        end
    endtask
    task wr(input logic [2:0] a, input logic [7:0] d);
        txn({2'b10, 3'h0, a, d}, 1'b0);
    endtask
    task hw_reset;
        begin
            rst_n <= 1'b0;
            repeat (16) @(posedge ref_clk);
            rst_n <= 1'b1;
            @(posedge ref_clk);
        end
    endtask
    task wrap_up;
        begin
            $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
            if (failures == 0 && cmp_count > 0) begin
                $display("TEST PASSED");
            end else begin
                $display("TEST FAILED");
            end
            $finish;
        end
    endtask
    initial begin
        rst_n = 1'b0;
        regv = '{8'h72, 8'h70, 8'h10, 8'hA5, 8'h3C, 8'hE0, 8'h00, 8'h00};
        @(posedge ref_clk);
        hw_reset;
        check(cfg(), 48'h0);
        wr(3'h0, 8'h72);
        check({casc, mix, opm, digital_loopback_enable, plb}, 7'h78);
        wr(3'h1, 8'h70);
        check({echo, mdiv, sdiv, srate}, 8'h70);
        for (i = 0; i < 4; i++) begin
            wr(3'h2, pwv[i]);
            check({adc_p, dac_p, ref_p, refout}, pwe[i]);
        end
        wr(3'h3, 8'hA5);
        wr(3'h4, 8'h3C);
        wr(3'h5, 8'hE0);
        wr(3'h6, 8'hFF);
        check({gain, conv, ana}, 24'hA53CE0);
        for (i = 0; i < 8; i++) begin
            txn({2'b11, 3'h0, i[2:0], 8'h00}, 1'b1);
            check(rx, {2'b11, 3'h0, i[2:0], regv[i]});
        end
        txn({2'b10, 3'h3, 3'h3, 8'h55}, 1'b1);
        check({rx, gain}, {2'b10, 3'h2, 3'h3, 8'h55, 8'hA5});
        txn({2'b00, 3'h0, 3'h3, 8'h11}, 1'b0);
        check(gain, 8'hA5);
        wr(3'h1, 8'hF0);
        txn({2'b10, 3'h0, 3'h3, 8'h66}, 1'b1);
        check({rx, gain, echo}, {16'h8366, 8'h66, 1'b1});
        wr(3'h0, 8'h80);
        repeat (8) @(posedge ref_clk);
        check(cfg(), 48'h0);
        wr(3'h3, 8'h5A);
        check(gain, 8'h5A);
        wr(3'h0, 8'h01);
        check(opm, 1'b1);
        wait_fs;
        got_q.delete();
        // Nine words against eight places: the last one must be refused
        for (i = 0; i < 9; i++) host.xfer(16'h8311 + {i[7:0], i[7:0]}, 1'b0, rx);
        repeat (10) wait_fs;
        check(got_q.size(), 8);
        for (i = 0; i < 8; i++) check(got_q[i], 16'h8311 + {i[7:0], i[7:0]});
        check(gain, 8'h5A);
        hw_reset;
        check(cfg(), 48'h0);
        wr(3'h3, 8'hC3);
        check(gain, 8'hC3);
        wrap_up;
    end
    initial begin
        #9500000;
        check(1'b0, 1'b1);
        wrap_up;
    end
endmodule
